// ===== core/hb_pin_map.sv
/*
 * Routes address latch and chip selects onto ext signals 16..27 and 30.
 * Assumes its inputs come from flip-flops on core_clk.
 */
`timescale 1ns/1ps
module hb_pin_map
  import host_bus_pkg::*;
(
  input  wire logic [1:0]  cs_arr,     // Chip select arrangement
  input  wire logic [11:0] upper_addr, // Address bits 16..27
  input  wire logic        ale,        // Address latch, active high
  input  wire logic [3:0]  sel_n,      // Decoded selects, active low
  output logic      [11:0] upper_pins, // Ext signals 16..27
  output logic             pin30       // Ext signal 30
);

  always_comb begin
    upper_pins = upper_addr;
    pin30      = ale;
    unique case (cs_arr)
      CS_ARR_ALE_ONLY: begin
        pin30 = ale;                                // see R10
      end
      CS_ARR_ONE_CS: begin
        pin30 = sel_n[0];                           // see R11
      end
      CS_ARR_TWO_CS: begin
        pin30          = sel_n[0];                  // see R13
        upper_pins[11] = sel_n[1];                  // see R13
      end
      CS_ARR_ALE_TWO_CS: begin
        pin30          = ale;                       // see R12
        upper_pins[10] = sel_n[0];                  // see R12
        upper_pins[11] = sel_n[1];                  // see R12
      end
    endcase
  end

endmodule : hb_pin_map

// ===== core/host_bus_muxed.sv
/*
 * 16-bit muxed host-bus engine: address phase with latch, then RD/WR strobe.
 * Assumes requests come from core_clk logic; read data pins are external.
 */
// How it works
// R1: Active only when interface mode is 0x3.
// R2: Phases stretched slower than general purpose.
// R3: Muxed mode puts address on AD pins.
// R4: Address bits 16..27 on dedicated pins.
// R5: Latch strobe during address; latch holds address.
// R6: Read on signal 28, write on 29.
// R7: Up to four chip selects drive peripherals; only selects 0 and 1 reach the pins.
// R8: Two byte selects; field 0x1 disables them.
// R9: Two-bit field picks latch/select arrangement.
// R10: Arrangement 0: latch on 30, address 16..27.
// R11: Arrangement 1: select 0 on 30.
// R12: Arrangement 3: latch 30, selects on 26, 27.
// R13: Arrangement 2: select 0 on 30, 1 on 27.
// R14: Latch phase ends before data strobe.
`timescale 1ns/1ps
module host_bus_muxed
  import host_bus_pkg::*;
(
  input  wire logic        core_clk,  // 50 MHz core clock
  input  wire logic        sys_rst,   // Async reset, active high
  input  wire hb_cfg_t     cfg,       // Configuration fields
  input  wire hb_req_t     req,       // Access request
  input  wire logic        req_valid, // Request valid
  output logic             req_ready, // Request accepted this cycle
  output logic [15:0]      rd_data,   // Captured read data
  output logic             done,      // One-cycle pulse, access finished
  output logic             busy,      // Access in progress
  input  wire logic [15:0] ad_in,     // Shared pins, input side
  output logic [15:0]      ad_out,    // Shared pins, output side
  output logic             ad_oe,     // Shared pins drive enable
  output logic [11:0]      upper_out, // Ext signals 16..27
  output logic             sig28_out, // Read strobe, active low
  output logic             sig29_out, // Write strobe, active low
  output logic             sig30_out, // Latch or select 0
  output logic [1:0]       byte_lane_select_n,    // Byte selects, active low
  output logic             byte_lane_select_oe    // Byte selects enabled
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ADDR   = 2'b01,
    ST_STROBE = 2'b11,
    ST_HOLD   = 2'b10
  } state_t;

  // ---------------------------------------------------------------
  // Configuration qualify
  // ---------------------------------------------------------------
  logic enabled;
  assign enabled = (cfg.iface_mode == IFACE_MODE_HB16) && // see R1
                   (cfg.hb_mode == HB_MODE_MUXED);        // see R3

  function automatic logic [3:0] sel_decode(input logic [1:0] idx, input logic on);
    sel_decode = 4'hf;
    if (on) begin
      sel_decode[idx] = 1'b0;
    end
  endfunction : sel_decode

  // ---------------------------------------------------------------
  // Sync inputs of the shared pins
  // ---------------------------------------------------------------
  logic [15:0] ad_meta_r;
  logic [15:0] ad_sync_r;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ad_meta_r <= 16'h0000;
      ad_sync_r <= 16'h0000;
    end else begin
      ad_meta_r <= ad_in;
      ad_sync_r <= ad_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------
  state_t                 state_r,  state_nxt;
  logic [PHASE_CNT_W-1:0] cnt_r,    cnt_nxt;
  hb_req_t                cur_r,    cur_nxt;
  hb_pins_t               pins_r,   pins_nxt;
  logic [3:0]             sel_r,    sel_nxt;
  logic                   ale_r,    ale_nxt;
  logic [15:0]            rdat_r,   rdat_nxt;
  logic                   done_r,   done_nxt;

  localparam logic [PHASE_CNT_W-1:0] ADDR_LAST   = PHASE_CNT_W'(ADDR_CYCLES - 1);
  localparam logic [PHASE_CNT_W-1:0] STROBE_LAST = PHASE_CNT_W'(STROBE_CYCLES - 1);
  localparam logic [PHASE_CNT_W-1:0] HOLD_LAST   = PHASE_CNT_W'(HOLD_CYCLES - 1);

  // Counter must reach the longest phase
  if (STROBE_CYCLES > (1 << PHASE_CNT_W) || HOLD_CYCLES > (1 << PHASE_CNT_W) ||
      ADDR_CYCLES < 1) begin : g_cnt_check
    $error("phase counter too narrow");
  end

  assign req_ready = (state_r == ST_IDLE) && enabled;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 1'b1;
    cur_nxt   = cur_r;
    sel_nxt   = sel_r;
    ale_nxt   = 1'b0;
    rdat_nxt  = rdat_r;
    done_nxt  = 1'b0;
    pins_nxt  = pins_r;
    pins_nxt.sig28   = 1'b1;
    pins_nxt.sig29   = 1'b1;
    pins_nxt.byte_lane_select_oe = (cfg.byte_sel != BYTE_SEL_OFF);             // see R8
    unique case (state_r)
      ST_IDLE: begin
        cnt_nxt = '0;
        sel_nxt = 4'hf;
        pins_nxt.ad_oe  = 1'b0;
        pins_nxt.byte_lane_select_n = 2'b11;
        if (req_valid && enabled) begin
          cur_nxt   = req;
          state_nxt = ST_ADDR;
          ale_nxt   = 1'b1;                                         // see R5
          sel_nxt   = sel_decode(req.target, 1'b1);                 // see R7
          pins_nxt.ad_out = req.addr[15:0];                         // see R3
          pins_nxt.ad_oe  = 1'b1;
          pins_nxt.upper  = req.addr[27:16];                        // see R4
        end
      end
      ST_ADDR: begin
        ale_nxt = 1'b1;
        if (cnt_r == ADDR_LAST) begin
          // Latch drops two cycles before strobe, one before the data swap, so address is held
          ale_nxt   = 1'b0;                                         // see R14
          state_nxt = ST_STROBE;
          cnt_nxt   = '0;
        end
      end
      ST_STROBE: begin
        if (cnt_r == '0) begin
          // First strobe cycle: swap AD pins from address to data
          pins_nxt.ad_out = cur_r.wdata;
          pins_nxt.ad_oe  = cur_r.write;
          pins_nxt.byte_lane_select_n = ~cur_r.lanes;                           // see R8
        end
        pins_nxt.sig28 = cur_r.write || (cnt_r == '0);              // see R6
        pins_nxt.sig29 = !cur_r.write || (cnt_r == '0);             // see R6
        if (cnt_r == STROBE_LAST) begin
          pins_nxt.sig28 = 1'b1;
          pins_nxt.sig29 = 1'b1;
          state_nxt = ST_HOLD;                                      // see R2
          cnt_nxt   = '0;
        end
      end
      ST_HOLD: begin
        // Two sync flops delay the pins, so read data lands one cycle late
        if (cnt_r == '0 && !cur_r.write) begin
          rdat_nxt = ad_sync_r;                                     // see R6
        end
        if (cnt_r == HOLD_LAST) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
          sel_nxt   = 4'hf;
          pins_nxt.ad_oe  = 1'b0;
          pins_nxt.byte_lane_select_n = 2'b11;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      cur_r   <= '0;
      sel_r   <= 4'hf;
      ale_r   <= 1'b0;
      rdat_r  <= 16'h0000;
      done_r  <= 1'b0;
      pins_r  <= '{ad_out: 16'h0000, ad_oe: 1'b0, upper: 12'h000, sig28: 1'b1,
                   sig29: 1'b1, sig30: 1'b0, byte_lane_select_n: 2'h3, byte_lane_select_oe: 1'b0};
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cur_r   <= cur_nxt;
      sel_r   <= sel_nxt;
      ale_r   <= ale_nxt;
      rdat_r  <= rdat_nxt;
      done_r  <= done_nxt;
      pins_r  <= pins_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Pin arrangement
  // ---------------------------------------------------------------
  hb_pin_map u_pin_map (
    .cs_arr     (cfg.cs_arr),                                       // see R9
    .upper_addr (pins_r.upper),
    .ale        (ale_r),
    .sel_n      (sel_r),
    .upper_pins (upper_out),
    .pin30      (sig30_out)
  );

  assign ad_out    = pins_r.ad_out;
  assign ad_oe     = pins_r.ad_oe;
  assign sig28_out = pins_r.sig28;
  assign sig29_out = pins_r.sig29;
  assign byte_lane_select_n    = pins_r.byte_lane_select_oe ? pins_r.byte_lane_select_n : 2'b11;
  assign byte_lane_select_oe   = pins_r.byte_lane_select_oe;
  assign rd_data   = rdat_r;
  assign done      = done_r;
  assign busy      = (state_r != ST_IDLE);

endmodule : host_bus_muxed

// ===== core/host_bus_pkg.sv
/*
 * Shared constants and carrier types for the 16-bit muxed host-bus port.
 * Assumes a single 50 MHz core clock and no register bus; config is ports.
 */
package host_bus_pkg;

  // ---------------------------------------------------------------
  // Configuration encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] IFACE_MODE_HB16   = 2'h3;
  localparam logic [1:0] HB_MODE_MUXED     = 2'h0;
  localparam logic [1:0] BYTE_SEL_OFF      = 2'h1;
  localparam logic [1:0] CS_ARR_ALE_ONLY   = 2'h0;
  localparam logic [1:0] CS_ARR_ONE_CS     = 2'h1;
  localparam logic [1:0] CS_ARR_TWO_CS     = 2'h2;
  localparam logic [1:0] CS_ARR_ALE_TWO_CS = 2'h3;

  // ---------------------------------------------------------------
  // Timing, in ns and derived core_clk cycles
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int ADDR_PHASE_NS   = 40;
  localparam int STROBE_PHASE_NS = 80;
  localparam int HOLD_PHASE_NS   = 20;
  localparam int ADDR_CYCLES     = (ADDR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES   = (STROBE_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYCLES     = (HOLD_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_CNT_W     = 4;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] iface_mode;   // interface_config_reg mode
    logic [1:0] hb_mode;      // hostbus_config_reg mode
    logic [1:0] byte_sel;     // byte_lane_select
    logic [1:0] cs_arr;       // chip_select_arrangement
  } hb_cfg_t;

  typedef struct packed {
    logic        write;
    logic [27:0] addr;
    logic [15:0] wdata;
    logic [1:0]  lanes;       // bit0 low byte, bit1 high byte
    logic [1:0]  target;      // peripheral index 0..3
  } hb_req_t;

  typedef struct packed {
    logic [15:0] ad_out;
    logic        ad_oe;
    logic [11:0] upper;       // ext signals 16..27
    logic        sig28;       // read strobe, active low
    logic        sig29;       // write strobe, active low
    logic        sig30;
    logic [1:0]  byte_lane_select_n;
    logic        byte_lane_select_oe;
  } hb_pins_t;

endpackage : host_bus_pkg

// ===== verif/hb_ext_latch.sv
/* Far-side model: external address latch plus one peripheral.
 * Assumes le is high while the device shows the address. */
`timescale 1ns/1ps
module hb_ext_latch (
  input  wire logic        clk,     // Clock
  input  wire logic        le,      // Latch enable
  input  wire logic        rd_n,    // Read strobe
  input  wire logic [15:0] ad_out,  // Device drive
  input  wire logic [15:0] rd_word, // Word served
  output logic      [15:0] ad_in,   // Pins seen by device
  output logic      [15:0] latched  // Held address
);
  initial ad_in = 16'h0f0f;
  always @* if (le) latched = ad_out;
  // Data follows the read strobe half a cycle later; released lines show the inverse
  always @(negedge clk) ad_in <= !rd_n ? rd_word : ~rd_word;
endmodule : hb_ext_latch

// ===== verif/host_bus_muxed_chk.sv
/* Port checker for the muxed host-bus engine.
 * Assumes binding onto every host_bus_muxed instance. */
`timescale 1ns/1ps
module host_bus_muxed_chk
  import host_bus_pkg::*;
(
  input wire logic        core_clk,  // Clock
  input wire logic        sys_rst,   // Reset
  input wire hb_cfg_t     cfg,       // Config
  input wire logic        req_valid, // Valid
  input wire logic        req_ready, // Ready
  input wire logic        done,      // Done
  input wire logic        busy,      // Busy
  input wire logic        ad_oe,     // Pin enable
  input wire logic [11:0] upper_out, // Signals 16..27
  input wire logic        sig28_out, // Read strobe
  input wire logic        sig29_out, // Write strobe
  input wire logic        sig30_out, // Signal 30
  input wire logic [1:0]  byte_lane_select_n     // Byte selects
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ready_mode: assert property (req_ready |-> cfg.iface_mode == IFACE_MODE_HB16 &&
    cfg.hb_mode == HB_MODE_MUXED && !busy) else $error("ready outside muxed mode");
  a_slow_cycle: assert property (req_valid && req_ready |=> !done [*5] ##[1:5] done)
    else $error("access length wrong");
  a_rd_width: assert property ($fell(sig28_out) |-> !sig28_out [*2] ##1 sig28_out)
    else $error("read strobe width wrong");
  a_one_strobe: assert property (!sig28_out |-> sig29_out && !ad_oe)
    else $error("read overlaps write or drive");
  a_ale_first: assert property ((cfg.cs_arr == CS_ARR_ALE_ONLY ||
    cfg.cs_arr == CS_ARR_ALE_TWO_CS) && sig30_out |-> sig28_out && sig29_out && ad_oe)
    else $error("latch overlaps strobe");
  a_byte_lane_select_off: assert property (cfg.byte_sel == BYTE_SEL_OFF |-> byte_lane_select_n == 2'h3)
    else $error("byte selects not off");
  a_two_sel: assert property (cfg.cs_arr == CS_ARR_TWO_CS |-> sig30_out || upper_out[11])
    else $error("two selects low");
  a_ale_two: assert property (cfg.cs_arr == CS_ARR_ALE_TWO_CS |->
    upper_out[10] || upper_out[11]) else $error("two selects low");
  a_idle_quiet: assert property (!busy |-> sig28_out && sig29_out)
    else $error("strobe while idle");
endmodule : host_bus_muxed_chk
bind host_bus_muxed host_bus_muxed_chk chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .cfg(cfg), .req_valid(req_valid), .req_ready(req_ready), .done(done), .busy(busy),
  .ad_oe(ad_oe), .upper_out(upper_out), .sig28_out(sig28_out), .sig29_out(sig29_out),
  .sig30_out(sig30_out), .byte_lane_select_n(byte_lane_select_n));

// ===== verif/host_bus_muxed_tb.sv
/* Self-checking bench for the muxed host-bus engine.
 * Assumes the external latch model and the bound checker. */
`timescale 1ns/1ps
module host_bus_muxed_tb;
  import host_bus_pkg::*;
  logic        core_clk  = 1'b0;
  logic        sys_rst   = 1'b1;
  hb_cfg_t     cfg       = '{IFACE_MODE_HB16, HB_MODE_MUXED, 2'h0, 2'h0};
  hb_req_t     req       = '0;
  logic        req_valid = 1'b0;
  logic        req_ready, done, busy, ad_oe, sig28_out, sig29_out, sig30_out, byte_lane_select_oe, le;
  logic [15:0] rd_data, ad_in, ad_out, latched, wd_seen;
  logic [11:0] upper_out, up_a, up_and;
  logic [1:0]  byte_lane_select_n;
  logic        s30_lo, s30_hi, bs_lo, s29_lo;
  int          error_cnt  = 0;
  int          num_checks = 0;
  always #10 core_clk = ~core_clk;
  assign le = (cfg.cs_arr == CS_ARR_ALE_ONLY || cfg.cs_arr == CS_ARR_ALE_TWO_CS) && sig30_out;
  host_bus_muxed dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data), .done(done),
    .busy(busy), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .upper_out(upper_out),
    .sig28_out(sig28_out), .sig29_out(sig29_out), .sig30_out(sig30_out),
    .byte_lane_select_n(byte_lane_select_n), .byte_lane_select_oe(byte_lane_select_oe));
  hb_ext_latch ext_u (.clk(core_clk), .le(le), .rd_n(sig28_out), .ad_out(ad_out),
    .rd_word(16'hc3a5), .ad_in(ad_in), .latched(latched));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task test_done;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Records pins over one access; the first cycle after taking is the address phase
  task acc(input logic w, input logic [27:0] a, input logic [1:0] t);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{w, a, 16'h5aa5, 2'h3, t};
    req_valid <= 1'b1;
    do begin @(negedge core_clk); n++; end while (req_ready !== 1'b1 && n < 20);
    @(posedge core_clk);
    req_valid <= 1'b0;
    {up_and, s30_lo, s30_hi, bs_lo, s29_lo, wd_seen} = {12'hfff, 4'h0, 16'h0000};
    for (int c = 1; c < 20 && done !== 1'b1; c++) begin
      @(negedge core_clk);
      if (c == 1) up_a = upper_out;
      up_and &= upper_out;
      s30_lo |= !sig30_out;
      s30_hi |= sig30_out;
      bs_lo |= !(&byte_lane_select_n);
      s29_lo |= !sig29_out;
      if (!sig29_out) wd_seen = ad_out;
    end
    if (done !== 1'b1 || n >= 20) begin
      chk("handshake", 1, 0);
      test_done();
    end
  endtask : acc
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_arrange;
    logic [27:0] a;
    for (int m = 0; m < 4; m++) begin
      a = 28'hb6d1e20 + 28'(m);
      @(posedge core_clk);
      cfg.cs_arr <= 2'(m);
      acc(1'b1, a, (m == 2) ? 2'h1 : 2'h0);
      chk("up_a low", {22'h0, a[25:16]}, {22'h0, up_a[9:0]});
      chk("write data", {1'b1, 16'h5aa5}, {s29_lo, wd_seen});
      case (m)
        0: chk("arr0", {a[27:16], 16'h0001, a[15:0] == latched}, {up_a, 16'h0001, 1'b1});
        1: chk("arr1", {a[27:16], 1'b1}, {up_a, s30_lo});
        2: chk("arr2", {a[26], 3'b001}, {up_and[10], up_and[11], s30_lo, s30_hi});
        default: chk("arr3", {a[15:0], 3'b101}, {latched, up_and[11], up_and[10], s30_hi});
      endcase
    end
    $display("test arrangements done");
  endtask : t_arrange
  task t_lanes;
    @(posedge core_clk);
    cfg.cs_arr <= CS_ARR_ALE_ONLY;
    acc(1'b0, 28'h0003c5a, 2'h0);
    chk("rd_data", 16'hc3a5, rd_data);
    chk("read no wr", 0, s29_lo);
    chk("byte_lane_select on", 2'h3, {bs_lo, byte_lane_select_oe});
    @(posedge core_clk);
    cfg.byte_sel <= BYTE_SEL_OFF;
    acc(1'b1, 28'h0001111, 2'h0);
    chk("byte_lane_select off", 0, {bs_lo, byte_lane_select_oe});
    $display("test lanes done");
  endtask : t_lanes
  task t_refuse;
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk);
      cfg.iface_mode <= (m == 0) ? 2'h2 : IFACE_MODE_HB16;
      cfg.hb_mode <= (m == 0) ? HB_MODE_MUXED : 2'h1;
      req_valid <= 1'b1;
      repeat (6) begin
        @(negedge core_clk);
        chk("ready busy", 0, {req_ready, busy});
      end
      @(posedge core_clk);
      req_valid <= 1'b0;
    end
    cfg <= '{IFACE_MODE_HB16, HB_MODE_MUXED, 2'h0, 2'h0};
    acc(1'b1, 28'h0002222, 2'h0);
    $display("test refusal done");
  endtask : t_refuse
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_arrange();
    t_lanes();
    t_refuse();
    test_done();
  end
endmodule : host_bus_muxed_tb
